// ===== pfm_pin_mux.sv
// Shared-pin function mux with reset defaults for bank zero, host, serial
`timescale 1ns/1ns
`include "pfm_map.svh"
module pfm_pin_mux import pfm_pkg::*; #(
    parameter int SP_W = 6
) (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    // Selection bundle
    input  wire pfm_cfg_t                  cfg,
    // Core GPIO and interrupt side
    input  wire logic [`PFM_GP_W-1:0]      gpio_out,
    output logic      [`PFM_GP_W-1:0]      gpio_in_q,
    output logic      [`PFM_INT_W-1:0]     external_interrupt_input_q,
    // PCI signals sharing bank-zero pins
    input  wire logic [1:0]                pci_gp_out,
    input  wire logic [1:0]                pci_gp_oe,
    output logic      [1:0]                pci_gp_in_q,
    // Bank-zero pads
    input  wire logic [`PFM_GP_W-1:0]      pad_gp0_in,
    output logic      [`PFM_GP_W-1:0]      pad_gp0_out_q,
    output logic      [`PFM_GP_W-1:0]      pad_gp0_oe_n_q,
    // Host, PCI and MAC data sides
    input  wire logic [`PFM_HD_W-1:0]      host_out,
    input  wire logic                      host_oe,
    output logic      [`PFM_HD_W-1:0]      host_in_q,
    input  wire logic [`PFM_HD_W-1:0]      pci_out,
    input  wire logic                      pci_oe,
    output logic      [`PFM_HD_W-1:0]      pci_in_q,
    input  wire logic [`PFM_HD_UP_W-1:0]   ethernet_mac_block_out,
    input  wire logic                      ethernet_mac_block_oe,
    output logic      [`PFM_HD_UP_W-1:0]   ethernet_mac_block_in_q,
    // Host/PCI data pads
    input  wire logic [`PFM_HD_W-1:0]      pad_hd_in,
    output logic      [`PFM_HD_W-1:0]      pad_hd_out_q,
    output logic      [`PFM_HD_W-1:0]      pad_hd_oe_n_q,
    // Management pins, PCI and management sides
    input  wire logic [`PFM_MD_W-1:0]      pci_md_out,
    input  wire logic [`PFM_MD_W-1:0]      pci_md_oe,
    output logic      [`PFM_MD_W-1:0]      pci_md_in_q,
    input  wire logic [`PFM_MD_W-1:0]      mgmt_out,
    input  wire logic [`PFM_MD_W-1:0]      mgmt_oe,
    output logic      [`PFM_MD_W-1:0]      mgmt_in_q,
    input  wire logic [`PFM_MD_W-1:0]      pad_md_in,
    output logic      [`PFM_MD_W-1:0]      pad_md_out_q,
    output logic      [`PFM_MD_W-1:0]      pad_md_oe_n_q,
    // Serial port / video port sides, two ports packed
    input  wire logic [2*SP_W-1:0]         sp_out,
    input  wire logic [2*SP_W-1:0]         sp_oe,
    output logic      [2*SP_W-1:0]         sp_in_q,
    input  wire logic [2*SP_W-1:0]         vp_out,
    input  wire logic [2*SP_W-1:0]         vp_oe,
    output logic      [2*SP_W-1:0]         vp_in_q,
    input  wire logic [2*SP_W-1:0]         pad_sp_in,
    output logic      [2*SP_W-1:0]         pad_sp_out_q,
    output logic      [2*SP_W-1:0]         pad_sp_oe_n_q,
    // Timestamp clock
    input  wire logic                      pad_video_timestamp_clock_in,
    output logic      [`PFM_VP_N-1:0]      vp_video_timestamp_clock_q,
    // Clock multiplier straps
    input  wire logic [1:0]                clock_multiplier_select,
    output logic      [3:0]                pll_mult_q,
    output logic                           clock_multiplier_select_bad_q
);
    initial begin
        if (SP_W < 1) begin
            $error("pfm_pin_mux: SP_W must be at least 1");
        end
    end

    // ----------------------------------------------------------------
    // Selection state
    // ----------------------------------------------------------------
    pfm_cfg_t cfg_q;
    logic     clk_quarter_out;
    logic     clk_sixth_out;

    // Defaults hold until configuration logic rewrites them
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfg_q.gp_en   <= `PFM_RST_GP_EN;
            cfg_q.gp_dir  <= `PFM_RST_GP_DIR;
            cfg_q.pci_en  <= 1'b0;
            cfg_q.ethernet_mac_block_en <= 1'b0;
            cfg_q.mdio_en <= 1'b0;
            cfg_q.sp_en   <= `PFM_RST_SP_EN;
        end else begin
            cfg_q <= cfg;
        end
    end

    // ----------------------------------------------------------------
    // Divided clock outputs
    // ----------------------------------------------------------------
    pfm_clk_div #(.DIV(`PFM_DIV_QUARTER)) u_div_quarter (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clk_q   (clk_quarter_out)
    );

    pfm_clk_div #(.DIV(`PFM_DIV_SIXTH)) u_div_sixth (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clk_q   (clk_sixth_out)
    );

    // ----------------------------------------------------------------
    // Bank-zero pins
    // ----------------------------------------------------------------
    logic [`PFM_GP_W-1:0] gp_out_d;
    logic [`PFM_GP_W-1:0] gp_oe_n_d;
    logic [`PFM_GP_W-1:0] gp_in_d;
    logic                 pci_pin;
    logic                 gpio_sel;

    // Per-pin owner: clock, PCI, GPIO or nothing
    always_comb begin
        gp_out_d  = '0;
        gp_oe_n_d = '1;
        gp_in_d   = '0;
        pci_pin   = 1'b0;
        gpio_sel  = 1'b0;
        for (int b = 0; b < `PFM_GP_W; b++) begin
            pci_pin  = (b == `PFM_GP_PCI_A) || (b == `PFM_GP_PCI_B);
            gpio_sel = cfg_q.gp_en[b] && !(pci_pin && cfg_q.pci_en);
            if (gpio_sel) begin
                gp_out_d[b]  = gpio_out[b];
                gp_oe_n_d[b] = ~cfg_q.gp_dir[b];
                gp_in_d[b]   = pad_gp0_in[b];
            end else if (b >= `PFM_GP_INT_LO) begin
                gp_in_d[b]   = pad_gp0_in[b];
            end
        end
        // Clock role wins whenever the GPIO enable is clear
        if (!cfg_q.gp_en[`PFM_GP_CLKQ]) begin
            gp_out_d[`PFM_GP_CLKQ]  = clk_quarter_out;
            gp_oe_n_d[`PFM_GP_CLKQ] = 1'b0;
        end
        if (!cfg_q.gp_en[`PFM_GP_CLKS]) begin
            gp_out_d[`PFM_GP_CLKS]  = clk_sixth_out;
            gp_oe_n_d[`PFM_GP_CLKS] = 1'b0;
        end
        // PCI owns its two pins only once enabled; GPIO role or idle otherwise
        if (cfg_q.pci_en) begin
            gp_out_d[`PFM_GP_PCI_A]  = pci_gp_out[0];
            gp_oe_n_d[`PFM_GP_PCI_A] = ~pci_gp_oe[0];
            gp_out_d[`PFM_GP_PCI_B]  = pci_gp_out[1];
            gp_oe_n_d[`PFM_GP_PCI_B] = ~pci_gp_oe[1];
        end
    end

    // Registered pad drive and core-side inputs
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pad_gp0_out_q  <= '0;
            pad_gp0_oe_n_q <= '1;
            gpio_in_q      <= '0;
            external_interrupt_input_q      <= '0;
            pci_gp_in_q    <= '0;
        end else begin
            pad_gp0_out_q  <= gp_out_d;
            pad_gp0_oe_n_q <= gp_oe_n_d;
            gpio_in_q      <= gp_in_d;
            external_interrupt_input_q      <= pad_gp0_in[`PFM_GP_INT_HI:`PFM_GP_INT_LO];
            // Unselected PCI side sees zero
            pci_gp_in_q    <= cfg_q.pci_en ?
                              {pad_gp0_in[`PFM_GP_PCI_B], pad_gp0_in[`PFM_GP_PCI_A]} : 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // Host/PCI/MAC data pins
    // ----------------------------------------------------------------
    pfm_fn_t fn_lo;
    pfm_fn_t fn_up;

    // Host unless PCI is enabled; MAC takes the upper half on request
    always_comb begin
        fn_lo = cfg_q.pci_en ? PFM_FN_PCI : PFM_FN_HOST;
        fn_up = cfg_q.ethernet_mac_block_en ? PFM_FN_ETHERNET_MAC_BLOCK : fn_lo;
    end

    // One owner per half drives and sees the pads
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pad_hd_out_q  <= '0;
            pad_hd_oe_n_q <= '1;
            host_in_q     <= '0;
            pci_in_q      <= '0;
            ethernet_mac_block_in_q     <= '0;
        end else begin
            host_in_q <= '0;
            pci_in_q  <= '0;
            ethernet_mac_block_in_q <= '0;
            unique case (fn_lo)
                PFM_FN_PCI: begin
                    pad_hd_out_q[`PFM_HD_UP_LO-1:0]  <= pci_out[`PFM_HD_UP_LO-1:0];
                    pad_hd_oe_n_q[`PFM_HD_UP_LO-1:0] <= {`PFM_HD_UP_LO{~pci_oe}};
                    pci_in_q[`PFM_HD_UP_LO-1:0]      <= pad_hd_in[`PFM_HD_UP_LO-1:0];
                end
                default: begin
                    pad_hd_out_q[`PFM_HD_UP_LO-1:0]  <= host_out[`PFM_HD_UP_LO-1:0];
                    pad_hd_oe_n_q[`PFM_HD_UP_LO-1:0] <= {`PFM_HD_UP_LO{~host_oe}};
                    host_in_q[`PFM_HD_UP_LO-1:0]     <= pad_hd_in[`PFM_HD_UP_LO-1:0];
                end
            endcase
            unique case (fn_up)
                PFM_FN_ETHERNET_MAC_BLOCK: begin
                    pad_hd_out_q[`PFM_HD_W-1:`PFM_HD_UP_LO]  <= ethernet_mac_block_out;
                    pad_hd_oe_n_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= {`PFM_HD_UP_W{~ethernet_mac_block_oe}};
                    ethernet_mac_block_in_q <= pad_hd_in[`PFM_HD_W-1:`PFM_HD_UP_LO];
                end
                PFM_FN_PCI: begin
                    pad_hd_out_q[`PFM_HD_W-1:`PFM_HD_UP_LO]  <= pci_out[`PFM_HD_W-1:`PFM_HD_UP_LO];
                    pad_hd_oe_n_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= {`PFM_HD_UP_W{~pci_oe}};
                    pci_in_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= pad_hd_in[`PFM_HD_W-1:`PFM_HD_UP_LO];
                end
                default: begin
                    pad_hd_out_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= host_out[`PFM_HD_W-1:`PFM_HD_UP_LO];
                    pad_hd_oe_n_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= {`PFM_HD_UP_W{~host_oe}};
                    host_in_q[`PFM_HD_W-1:`PFM_HD_UP_LO] <= pad_hd_in[`PFM_HD_W-1:`PFM_HD_UP_LO];
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Management pins
    // ----------------------------------------------------------------
    // PCI holds these by default but drives only once PCI is enabled
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pad_md_out_q  <= '0;
            pad_md_oe_n_q <= '1;
            pci_md_in_q   <= '0;
            mgmt_in_q     <= '0;
        end else if (cfg_q.mdio_en) begin
            pad_md_out_q  <= mgmt_out;
            pad_md_oe_n_q <= ~mgmt_oe;
            pci_md_in_q   <= '0;
            mgmt_in_q     <= pad_md_in;
        end else begin
            pad_md_out_q  <= pci_md_out;
            pad_md_oe_n_q <= cfg_q.pci_en ? ~pci_md_oe : '1;
            pci_md_in_q   <= cfg_q.pci_en ? pad_md_in : '0;
            mgmt_in_q     <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Serial port / video port pins
    // ----------------------------------------------------------------
    // Each port picks its owner independently
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pad_sp_out_q  <= '0;
            pad_sp_oe_n_q <= '1;
            sp_in_q       <= '0;
            vp_in_q       <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (cfg_q.sp_en[p]) begin
                    pad_sp_out_q[p*SP_W +: SP_W]  <= sp_out[p*SP_W +: SP_W];
                    pad_sp_oe_n_q[p*SP_W +: SP_W] <= ~sp_oe[p*SP_W +: SP_W];
                    sp_in_q[p*SP_W +: SP_W]       <= pad_sp_in[p*SP_W +: SP_W];
                    vp_in_q[p*SP_W +: SP_W]       <= '0;
                end else begin
                    pad_sp_out_q[p*SP_W +: SP_W]  <= vp_out[p*SP_W +: SP_W];
                    pad_sp_oe_n_q[p*SP_W +: SP_W] <= ~vp_oe[p*SP_W +: SP_W];
                    vp_in_q[p*SP_W +: SP_W]       <= pad_sp_in[p*SP_W +: SP_W];
                    sp_in_q[p*SP_W +: SP_W]       <= '0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Timestamp clock and multiplier straps
    // ----------------------------------------------------------------
    // A single flop fans out, so the ports can never disagree
    logic video_timestamp_clock_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            video_timestamp_clock_q <= 1'b0;
        end else begin
            video_timestamp_clock_q <= pad_video_timestamp_clock_in;
        end
    end
    assign vp_video_timestamp_clock_q = {`PFM_VP_N{video_timestamp_clock_q}};

    // Decode straps; an unlisted code is flagged, board must avoid it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pll_mult_q    <= `PFM_MULT_X1;
            clock_multiplier_select_bad_q <= 1'b0;
        end else begin
            clock_multiplier_select_bad_q <= 1'b0;
            unique case (clock_multiplier_select)
                `PFM_CM_X1:  pll_mult_q <= `PFM_MULT_X1;
                `PFM_CM_X6:  pll_mult_q <= `PFM_MULT_X6;
                `PFM_CM_X12: pll_mult_q <= `PFM_MULT_X12;
                default: begin
                    pll_mult_q    <= `PFM_MULT_X1;
                    clock_multiplier_select_bad_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_quarter_wave;
        clk_quarter_out [*2] ##1 !clk_quarter_out [*2];
    endsequence
    sequence s_sixth_wave;
        clk_sixth_out [*3] ##1 !clk_sixth_out [*3];
    endsequence

    a_clk_default_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !$past(cfg_q.gp_en[`PFM_GP_CLKQ]) |->
            !pad_gp0_oe_n_q[`PFM_GP_CLKQ] && pad_gp0_out_q[`PFM_GP_CLKQ] == $past(clk_quarter_out))
        else $error("quarter clock pin not driving clock");
    a_gpio_dir_input: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && $past(cfg_q.gp_en[`PFM_GP_CLKS] && !cfg_q.gp_dir[`PFM_GP_CLKS]) |->
            pad_gp0_oe_n_q[`PFM_GP_CLKS])
        else $error("input-only GPIO pin is driving");
    a_quarter_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(clk_quarter_out) |-> s_quarter_wave ##1 clk_quarter_out)
        else $error("quarter clock period wrong");
    a_sixth_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(clk_sixth_out) |-> s_sixth_wave ##1 clk_sixth_out)
        else $error("sixth clock period wrong");
    a_int_no_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && ($past(cfg_q.gp_en[`PFM_GP_INT_HI:`PFM_GP_INT_LO]
            & cfg_q.gp_dir[`PFM_GP_INT_HI:`PFM_GP_INT_LO]) == 4'h0) |->
            &pad_gp0_oe_n_q[`PFM_GP_INT_HI:`PFM_GP_INT_LO])
        else $error("interrupt pin driving without output enable");
    a_pci_gp_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !$past(cfg_q.pci_en) && !$past(cfg_q.gp_en[`PFM_GP_PCI_A]) |->
            pad_gp0_oe_n_q[`PFM_GP_PCI_A] && pci_gp_in_q == 2'h0 && !gpio_in_q[`PFM_GP_PCI_A])
        else $error("PCI-shared bank-zero pin active while idle");
    a_host_owns_bus: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !$past(cfg_q.pci_en) && !$past(cfg_q.ethernet_mac_block_en) |->
            pad_hd_oe_n_q == {`PFM_HD_W{~$past(host_oe)}} && pci_in_q == '0 && ethernet_mac_block_in_q == '0)
        else $error("data pins not owned by host port");
    a_md_pci_default: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !$past(cfg_q.mdio_en) |->
            mgmt_in_q == '0 && ($past(cfg_q.pci_en) || &pad_md_oe_n_q))
        else $error("management pins wrong owner");
    a_sp_video: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !$past(cfg_q.sp_en[0]) |->
            sp_in_q[SP_W-1:0] == '0 && vp_in_q[SP_W-1:0] == $past(pad_sp_in[SP_W-1:0]))
        else $error("serial port zero pins not with video port");
    a_video_timestamp_clock_shared: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) |-> vp_video_timestamp_clock_q == {`PFM_VP_N{$past(pad_video_timestamp_clock_in)}})
        else $error("timestamp clock copies differ");
    a_mult_decode: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && $past(clock_multiplier_select) == `PFM_CM_X12 |->
            pll_mult_q == `PFM_MULT_X12 && !clock_multiplier_select_bad_q)
        else $error("multiplier decode wrong");
endmodule

// ===== pfm_map.svh
// Pin-function mux constants: pin positions, divider ratios, defaults
// Contract
// - Clock pins default to clock outputs after reset
// - GPIO role needs enable bit; direction bit drives
// - Quarter clock pin toggles at core/4
// - Sixth clock pin toggles at core/6
// - Interrupt-capable pins do not drive after reset; they drive only with GPIO enable and direction set
// - PCI-shared bank-zero pins idle after reset
// - Host/PCI shared pins default to host port
// - PCI-shared pins: GPIO role or no function while PCI is off
// - Upper data pins default to host port
// - Management pins default to PCI role
// - Serial port pins default to video ports
// - One timestamp clock feeds all video ports
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// ----------------------------------------------------------------
// Bank-zero pin positions
// ----------------------------------------------------------------
`define PFM_GP_W        8
`define PFM_GP_PCI_A    0
`define PFM_GP_CLKQ     1
`define PFM_GP_CLKS     2
`define PFM_GP_PCI_B    3
`define PFM_GP_INT_LO   4
`define PFM_GP_INT_HI   7
`define PFM_INT_W       4

// ----------------------------------------------------------------
// Host/PCI data bus and shared upper half
// ----------------------------------------------------------------
`define PFM_HD_W        32
`define PFM_HD_UP_LO    16
`define PFM_HD_UP_W     16
`define PFM_MD_W        2
`define PFM_VP_N        3

// ----------------------------------------------------------------
// Divider ratios and multiplier codes
// ----------------------------------------------------------------
`define PFM_DIV_QUARTER 4
`define PFM_DIV_SIXTH   6
`define PFM_CM_X1       2'h0
`define PFM_CM_X6       2'h1
`define PFM_CM_X12      2'h2
`define PFM_MULT_X1     4'h1
`define PFM_MULT_X6     4'h6
`define PFM_MULT_X12    4'hC

// ----------------------------------------------------------------
// Reset defaults of the selection state
// ----------------------------------------------------------------
`define PFM_RST_GP_EN   8'h00
`define PFM_RST_GP_DIR  8'h00
`define PFM_RST_SP_EN   2'h0

`endif

// ===== pfm_pkg.sv
// Pin-function mux types: selection bundle and data-bus function codes
package pfm_pkg;

    // Selection bits from configuration logic, one bundle
    typedef struct packed {
        logic [7:0] gp_en;    // Per-pin GPIO enable
        logic [7:0] gp_dir;   // Per-pin direction, 1 = drive
        logic       pci_en;   // PCI owns host/PCI pins
        logic       ethernet_mac_block_en;  // MAC owns upper data pins
        logic       mdio_en;  // Management owns its pins
        logic [1:0] sp_en;    // Serial port owns its pins, per port
    } pfm_cfg_t;

    // Owner of a data-bus pin
    typedef enum logic [1:0] {
        PFM_FN_HOST = 2'b00,
        PFM_FN_PCI  = 2'b01,
        PFM_FN_ETHERNET_MAC_BLOCK = 2'b10
    } pfm_fn_t;

endpackage

// ===== pfm_clk_div.sv
// Even-ratio clock divider producing a square wave from the core clock
`timescale 1ns/1ns
`include "pfm_map.svh"
module pfm_clk_div import pfm_pkg::*; #(
    parameter int DIV = `PFM_DIV_QUARTER
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Divided output
    output logic      clk_q
);
    localparam int HALF = DIV / 2;
    localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    // Odd ratios cannot give a square wave from one edge
    initial begin
        if (DIV < 2 || (DIV % 2) != 0) begin
            $error("pfm_clk_div: DIV must be even and at least 2");
        end
    end

    logic [CW-1:0] cnt_q;

    // ----------------------------------------------------------------
    // Half-period counter, flips output on wrap
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            clk_q <= ~clk_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule

// ===== test_pfm_pin_mux.sv
// Self-checking bench for the shared-pin function mux and its reset defaults
`timescale 1ns/1ns
`include "pfm_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_pfm_pin_mux import pfm_pkg::*;;
    // ----------------------------------------------------------------
    // Design signals
    // ----------------------------------------------------------------
    logic        clk_sys, rstn, host_oe, pci_oe, ethernet_mac_block_oe, pad_video_timestamp_clock_in, clock_multiplier_select_bad_q;
    pfm_cfg_t    cfg;
    logic [7:0]  gpio_out, gpio_in_q, pad_gp0_in, pad_gp0_out_q, pad_gp0_oe_n_q;
    logic [3:0]  external_interrupt_input_q, pll_mult_q;
    logic [2:0]  vp_video_timestamp_clock_q;
    logic [1:0]  pci_gp_out, pci_gp_oe, pci_gp_in_q, pci_md_out, pci_md_oe, pci_md_in_q;
    logic [1:0]  mgmt_out, mgmt_oe, mgmt_in_q, pad_md_in, pad_md_out_q, pad_md_oe_n_q;
    logic [1:0]  clock_multiplier_select;
    logic [31:0] host_out, host_in_q, pci_out, pci_in_q, pad_hd_in, pad_hd_out_q, pad_hd_oe_n_q;
    logic [15:0] ethernet_mac_block_out, ethernet_mac_block_in_q;
    logic [11:0] sp_out, sp_oe, sp_in_q, vp_out, vp_oe, vp_in_q;
    logic [11:0] pad_sp_in, pad_sp_out_q, pad_sp_oe_n_q;
    int          err_total, samples_checked, cycle_count;
    logic        qv [24];
    logic        sv [24];
    // ----------------------------------------------------------------
    // Ordinary cases: selection word beside the pad states it should give
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [20:0] c;  logic [31:0] hd; logic [1:0] md; logic [11:0] sp;
        logic [7:0]  gp; logic [7:0]  gi; logic [31:0] hi; logic [31:0] pi;
        logic [15:0] ei; logic [1:0]  pg; logic [3:0]  mm; logic [23:0] vs;
    } pfm_row_t;
    // Extra columns: PCI, MAC, PCI bank-zero, {PCI md, mgmt} and {video, serial} inputs
    localparam pfm_row_t ROWS [6] = '{
        '{21'h000000, 32'hAAAAAAAA, 2'h3, 12'hFFF, 8'hF9, 8'h50, 32'h12345678,
          32'h00000000, 16'h0000, 2'h0, 4'h0, 24'hA5C000},
        '{21'h000010, 32'h55555555, 2'h0, 12'hFFF, 8'hF0, 8'h50, 32'h00000000,
          32'h12345678, 16'h0000, 2'h2, 4'h8, 24'hA5C000},
        '{21'h000008, 32'h3C3CAAAA, 2'h3, 12'hFFF, 8'hF9, 8'h50, 32'h00005678,
          32'h00000000, 16'h1234, 2'h0, 4'h0, 24'hA5C000},
        '{21'h000005, 32'hAAAAAAAA, 2'h0, 12'hFC0, 8'hF9, 8'h50, 32'h12345678,
          32'h00000000, 16'h0000, 2'h0, 4'h2, 24'hA4001C},
        '{21'h1FFE00, 32'hAAAAAAAA, 2'h3, 12'hFFF, 8'h0F, 8'h5A, 32'h12345678,
          32'h00000000, 16'h0000, 2'h0, 4'h0, 24'hA5C000},
        '{21'h1FFFF0, 32'h55555555, 2'h0, 12'hFFF, 8'h00, 8'h52, 32'h00000000,
          32'h12345678, 16'h0000, 2'h2, 4'h8, 24'hA5C000}};
    localparam logic [3:0] MULTS [4] = '{4'h1, 4'h6, 4'hC, 4'h1};

    pfm_pin_mux #(.SP_W(6)) dut_u (.*);

    // Free-running core clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard: the whole sequence needs well under 200 cycles
    always @(posedge clk_sys) begin
        cycle_count++;
        if (cycle_count == 500) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Every owner but the video ports drives so that a wrong owner shows on the pads
        rstn = 1'b0; cfg = '0; gpio_out = 8'hA5; pad_gp0_in = 8'h5A;
        pci_gp_out = 2'h3; pci_gp_oe = 2'h3; pci_md_out = 2'h0; pci_md_oe = 2'h3;
        mgmt_out = 2'h0; mgmt_oe = 2'h3; pad_md_in = 2'h2; host_out = 32'hAAAAAAAA;
        host_oe = 1'b1; pci_out = 32'h55555555; pci_oe = 1'b1; ethernet_mac_block_out = 16'h3C3C;
        ethernet_mac_block_oe = 1'b1; pad_hd_in = 32'h12345678; sp_out = 12'h000; sp_oe = 12'hFFF;
        vp_out = 12'hFFF; vp_oe = 12'h000; pad_sp_in = 12'hA5C; pad_video_timestamp_clock_in = 1'b0;
        clock_multiplier_select = 2'h0; err_total = 0; samples_checked = 0; cycle_count = 0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pad_gp0_oe_n_q, 8'hFF)
        @(posedge clk_sys) rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pad_gp0_oe_n_q, 8'hF9)
        `CHK(pad_hd_oe_n_q, 32'h00000000)
        `CHK(pad_md_oe_n_q, 2'h3)
        `CHK(pad_sp_oe_n_q, 12'hFFF)
        // Ratio check by half-period: independent of the dividers' phase
        for (int i = 0; i < 24; i++) begin
            @(negedge clk_sys);
            qv[i] = pad_gp0_out_q[1];
            sv[i] = pad_gp0_out_q[2];
        end
        for (int i = 6; i < 24; i++) begin
            `CHK(qv[i], ~qv[i-2])
            `CHK(sv[i], ~sv[i-3])
        end
        // Table of selections, two edges of latency plus one of margin
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys) cfg <= pfm_cfg_t'(ROWS[k].c);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK(pad_hd_out_q, ROWS[k].hd)
            `CHK(pad_md_oe_n_q, ROWS[k].md)
            `CHK(pad_sp_oe_n_q, ROWS[k].sp)
            `CHK(pad_sp_out_q, ROWS[k].sp)
            `CHK(pad_gp0_oe_n_q, ROWS[k].gp)
            `CHK(gpio_in_q, ROWS[k].gi)
            `CHK(host_in_q, ROWS[k].hi)
            `CHK(pci_in_q, ROWS[k].pi)
            `CHK(ethernet_mac_block_in_q, ROWS[k].ei)
            `CHK(pci_gp_in_q, ROWS[k].pg)
            `CHK({pci_md_in_q, mgmt_in_q}, ROWS[k].mm)
            `CHK({vp_in_q, sp_in_q}, ROWS[k].vs)
            `CHK(external_interrupt_input_q, 4'h5)
        end
        // Every strap code, including the unsupported one
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys) clock_multiplier_select <= 2'(m);
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK(pll_mult_q, MULTS[m])
            `CHK(clock_multiplier_select_bad_q, 1'(m == 3))
        end
        // One timestamp input reaches all three ports alike
        @(posedge clk_sys) pad_video_timestamp_clock_in <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(vp_video_timestamp_clock_q, 3'h7)
        @(posedge clk_sys) pad_video_timestamp_clock_in <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(vp_video_timestamp_clock_q, 3'h0)
        // Reset in mid-run with every pin but the serial ones handed to GPIO and PCI
        @(posedge clk_sys) rstn <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pad_hd_oe_n_q, 32'hFFFFFFFF)
        @(posedge clk_sys) cfg <= '0;
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pad_gp0_oe_n_q, 8'hF9)
        end_of_test();
    end
endmodule
